// >>> hdl/uss_core.sv
// universal serial shift core: shift register, edge counter, start/stop detect
// ---------------------------------------------------------------------------
// Summary of operation
// - start detection runs only in the two-wire modes
// - data line is delayed 50..300 ns before compare with the clock line
// - start detection works without bus activity and raises a wake output
// - external clock counts both rising and falling clock-pin edges
// - counter preloaded to F overflows on the next clock, setting the flag
// - cpu write to data register beats a coincident shift
// - data register shifts left on each clock from the selected source
// - inputs still feed shift and count when wire mode is zero
// - serial output follows bit 7 through a latch open in first half
// - data drives the pin only when its direction bit is one
// - transfer completion copies data into the read-only buffer
// - start flag set by start condition or by clock edges per mode
// - start request while start flag, enable and global enable are set
// - start flag cleared only by writing one; releases clock hold
// - overflow flag set when counter wraps from 15 to 0
// - overflow request while flag, enable and global enable set
// - overflow flag cleared only by writing one; releases clock hold
// - stop flag set on stop condition, cleared by one, no request
// - collision bit reads one when bit 7 differs from the pin level
// - counter readable, writable, counts each selected clock
// - with external source and software bit, toggle strobe clocks counter
// - wire mode: 00 off, 01 three-wire, 10/11 two-wire open drain
// - two-wire: clock held low after start until start flag cleared
// - mode 11 also holds clock low after overflow until flag cleared
// - clock select 00: software bit clocks shift and count once
// ---------------------------------------------------------------------------
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
module uss_core
  import uss_pkg::*;
#(
  parameter int SYNC_STAGES = 3
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_global_ie,
  input wire logic i_timer_match,
  input wire logic i_data_dir,
  input wire logic i_clock_dir,
  input wire logic i_data_port,
  input wire logic i_clock_port,
  input wire logic i_serial_in_pin,
  input wire logic i_shift_clock_pin,
  output logic o_data_out,
  output logic o_data_oe_n,
  output logic o_clock_out,
  output logic o_clock_oe_n,
  output logic o_start_irq,
  output logic o_overflow_irq,
  output logic o_start_wake
);
  // ---------------------------------------------------------------------------
  // pin synchronisers: three stages, change seen once stages 2 and 3 agree
  // ---------------------------------------------------------------------------
  logic [SYNC_STAGES-1:0] sdi_sync_q, sdi_sync_d;
  logic [SYNC_STAGES-1:0] sck_sync_q, sck_sync_d;
  logic sdi_q, sdi_d, sck_q, sck_d;
  logic [USS_SDA_DELAY_CYC-1:0] sdi_dly_q, sdi_dly_d;

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  logic start_ie_q, start_ie_d, ovf_ie_q, ovf_ie_d;
  logic [1:0] wm_q, wm_d, cs_q, cs_d;
  logic sw_clk_q, sw_clk_d;
  logic start_flag_q, start_flag_d, ovf_flag_q, ovf_flag_d, stop_flag_q, stop_flag_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] data_q, data_d, buf_q, buf_d, rdata_q, rdata_d;
  logic latch_q, latch_d, hold_start_q, hold_start_d;

  // combinational decode
  logic wr_ctrl, wr_stat, wr_data, two_wire, ext_sel;
  logic sck_rise, sck_fall, sck_edge, sdi_dly_prev, sdi_dly_now;
  logic start_det, stop_det, tick_ext, shift_clk, count_clk, sw_strobe, tc_strobe;
  logic wrap;

  // both two-wire codes share everything but the overflow hold
  function automatic logic uss_two_wire(input logic [1:0] wm);
    return (wm == USS_WM_TWO) || (wm == USS_WM_TWO_HOLD);
  endfunction

  // one bus strobe aimed at one register offset
  function automatic logic uss_hit(input logic strobe, input logic [7:0] addr,
                                   input logic [7:0] target);
    return strobe && (addr == target);
  endfunction

  // ---------------------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    sdi_sync_d = {sdi_sync_q[SYNC_STAGES-2:0], i_serial_in_pin};
    sck_sync_d = {sck_sync_q[SYNC_STAGES-2:0], i_shift_clock_pin};
    // stage 1 feeds only stage 2; filtered level moves when 2 and 3 agree
    sdi_d = (sdi_sync_q[1] == sdi_sync_q[2]) ? sdi_sync_q[2] : sdi_q;
    sck_d = (sck_sync_q[1] == sck_sync_q[2]) ? sck_sync_q[2] : sck_q;
    sdi_dly_d = {sdi_dly_q[USS_SDA_DELAY_CYC-2:0], sdi_q};
  end

  // edge detection, address decode and clock-source choice
  always_comb begin
    sdi_dly_now = sdi_dly_q[USS_SDA_DELAY_CYC-1];
    sdi_dly_prev = sdi_dly_q[USS_SDA_DELAY_CYC-2];
    sck_rise = sck_d & ~sck_q;
    sck_fall = ~sck_d & sck_q;
    sck_edge = sck_rise | sck_fall;
    two_wire = uss_two_wire(wm_q);
    ext_sel = cs_q[1];
    // start: delayed data falls while clock is high; stop: rises while high
    start_det = two_wire & sck_q & sdi_dly_now & ~sdi_dly_prev;
    stop_det = two_wire & sck_q & ~sdi_dly_now & sdi_dly_prev;
    wr_ctrl = uss_hit(i_wr, i_addr, USS_ADDR_CONTROL);
    wr_stat = uss_hit(i_wr, i_addr, USS_ADDR_STATUS);
    wr_data = uss_hit(i_wr, i_addr, USS_ADDR_DATA);
    sw_strobe = wr_ctrl & i_wdata[USS_CR_SW_CLK];
    tc_strobe = wr_ctrl & i_wdata[USS_CR_TOGGLE];
    // cs[0] picks sampling edge for the shift; both edges count
    tick_ext = cs_q[0] ? sck_fall : sck_rise;
    shift_clk = 1'b0;
    count_clk = 1'b0;
    unique case (cs_q)
      USS_CS_SOFT: begin
        shift_clk = sw_strobe;
        count_clk = sw_strobe;
      end
      USS_CS_TIMER: begin
        shift_clk = i_timer_match;
        count_clk = i_timer_match;
      end
      default: begin
        shift_clk = tick_ext;
        count_clk = sw_clk_q ? tc_strobe : sck_edge;
      end
    endcase
  end

  // control register; strobes are not stored as readable state
  always_comb begin
    start_ie_d = start_ie_q;
    ovf_ie_d = ovf_ie_q;
    wm_d = wm_q;
    cs_d = cs_q;
    sw_clk_d = sw_clk_q;
    if (wr_ctrl) begin
      start_ie_d = i_wdata[USS_CR_START_IE];
      ovf_ie_d = i_wdata[USS_CR_OVF_IE];
      wm_d = i_wdata[USS_CR_WM_HI:USS_CR_WM_LO];
      cs_d = i_wdata[USS_CR_CS_HI:USS_CR_CS_LO];
      sw_clk_d = i_wdata[USS_CR_SW_CLK];
    end
  end

  // counter: cpu write wins over a count in the same cycle
  always_comb begin
    wrap = count_clk && (cnt_q == USS_CNT_MAX);
    cnt_d = count_clk ? cnt_q + USS_CNT_ONE : cnt_q;
    if (wr_stat) begin
      cnt_d = i_wdata[USS_SR_CNT_HI:USS_SR_CNT_LO];
    end
  end

  // data register: write beats shift
  always_comb begin
    data_d = shift_clk ? {data_q[6:0], sdi_q} : data_q;
    if (wr_data) begin
      data_d = i_wdata;
    end
    buf_d = wrap ? data_d : buf_q;
  end

  // flags: set beats write-one clear
  always_comb begin
    start_flag_d = start_flag_q;
    if (wr_stat && i_wdata[USS_SR_START]) begin
      start_flag_d = 1'b0;
    end
    if (start_det || (!two_wire && ext_sel && !sw_clk_q && sck_edge)) begin
      start_flag_d = 1'b1;
    end
    ovf_flag_d = ovf_flag_q;
    if (wr_stat && i_wdata[USS_SR_OVF]) begin
      ovf_flag_d = 1'b0;
    end
    if (wrap) begin
      ovf_flag_d = 1'b1;
    end
    stop_flag_d = stop_flag_q;
    if (wr_stat && i_wdata[USS_SR_STOP]) begin
      stop_flag_d = 1'b0;
    end
    if (stop_det) begin
      stop_flag_d = 1'b1;
    end
    // start hold arms on the clock falling after a start, drops with the flag
    hold_start_d = hold_start_q;
    if (!start_flag_q || !two_wire) begin
      hold_start_d = 1'b0;
    end else if (sck_fall) begin
      hold_start_d = 1'b1;
    end
  end

  // output latch: open while clock is low (first half) for external source
  always_comb begin
    latch_d = (!ext_sel || !sck_q) ? data_d[7] : latch_q;
  end

  // read mux, answer one cycle after the strobe
  always_comb begin
    rdata_d = USS_RESET_VALUE;
    if (i_rd) begin
      unique case (i_addr)
        USS_ADDR_CONTROL: rdata_d = {start_ie_q, ovf_ie_q, wm_q, cs_q, 2'b00};
        USS_ADDR_STATUS: rdata_d = {start_flag_q, ovf_flag_q, stop_flag_q,
                                     (data_q[7] != sdi_q), cnt_q};
        USS_ADDR_DATA: rdata_d = data_q;
        USS_ADDR_BUFFER: rdata_d = buf_q;
        default: rdata_d = USS_RESET_VALUE;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------------------
  // synchronisers reset to the idle-high line level so no false edge follows reset
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      sdi_sync_q <= '1;
      sck_sync_q <= '1;
      sdi_q <= 1'b1;
      sck_q <= 1'b1;
      sdi_dly_q <= '1;
    end else begin
      sdi_sync_q <= sdi_sync_d;
      sck_sync_q <= sck_sync_d;
      sdi_q <= sdi_d;
      sck_q <= sck_d;
      sdi_dly_q <= sdi_dly_d;
    end
  end

  // control register
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      start_ie_q <= 1'b0;
      ovf_ie_q <= 1'b0;
      wm_q <= USS_WM_OFF;
      cs_q <= USS_CS_SOFT;
      sw_clk_q <= 1'b0;
    end else begin
      start_ie_q <= start_ie_d;
      ovf_ie_q <= ovf_ie_d;
      wm_q <= wm_d;
      cs_q <= cs_d;
      sw_clk_q <= sw_clk_d;
    end
  end

  // edge counter
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // shift data and the buffer it lands in
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      data_q <= USS_RESET_VALUE;
      buf_q <= USS_RESET_VALUE;
    end else begin
      data_q <= data_d;
      buf_q <= buf_d;
    end
  end

  // flags and the start hold
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      start_flag_q <= 1'b0;
      ovf_flag_q <= 1'b0;
      stop_flag_q <= 1'b0;
      hold_start_q <= 1'b0;
    end else begin
      start_flag_q <= start_flag_d;
      ovf_flag_q <= ovf_flag_d;
      stop_flag_q <= stop_flag_d;
      hold_start_q <= hold_start_d;
    end
  end

  // output latch
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      latch_q <= 1'b0;
    end else begin
      latch_q <= latch_d;
    end
  end

  // read data, zero outside the answer cycle
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      rdata_q <= USS_RESET_VALUE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ---------------------------------------------------------------------------
  // pins and requests
  // ---------------------------------------------------------------------------
  // three-wire drives push-pull; two-wire only pulls low (open drain)
  always_comb begin
    o_rdata = rdata_q;
    o_data_out = 1'b1;
    o_data_oe_n = 1'b1;
    o_clock_out = 1'b0;
    o_clock_oe_n = 1'b1;
    if (wm_q == USS_WM_THREE) begin
      o_data_out = latch_q;
      o_data_oe_n = ~i_data_dir;
    end else if (two_wire) begin
      o_data_out = 1'b0;
      o_data_oe_n = ~(i_data_dir & (~latch_q | ~i_data_port));
      // gating with the flag lets the line go in the very cycle the flag is cleared
      o_clock_oe_n = ~(i_clock_dir & (~i_clock_port | (hold_start_q & start_flag_q)
                     | ((wm_q == USS_WM_TWO_HOLD) & ovf_flag_q)));
    end
  end

  // requests are plain levels: flag, its enable and the global enable
  always_comb begin
    o_start_irq = start_flag_q & start_ie_q & i_global_ie;
    o_overflow_irq = ovf_flag_q & ovf_ie_q & i_global_ie;
    o_start_wake = o_start_irq;
  end
endmodule

// >>> hdl/uss_pkg.sv
// package for the universal serial shift core: register map, fields, timing
package uss_pkg;
  // -------------------------------------------------------------------------
  // register offsets
  // -------------------------------------------------------------------------
  localparam logic [7:0] USS_ADDR_CONTROL = 8'hB8;
  localparam logic [7:0] USS_ADDR_STATUS = 8'hB9;
  localparam logic [7:0] USS_ADDR_DATA = 8'hBA;
  localparam logic [7:0] USS_ADDR_BUFFER = 8'hBB;
  localparam logic [7:0] USS_RESET_VALUE = 8'h00;
  // -------------------------------------------------------------------------
  // control field positions
  // -------------------------------------------------------------------------
  localparam int USS_CR_START_IE = 7;
  localparam int USS_CR_OVF_IE = 6;
  localparam int USS_CR_WM_HI = 5;
  localparam int USS_CR_WM_LO = 4;
  localparam int USS_CR_CS_HI = 3;
  localparam int USS_CR_CS_LO = 2;
  localparam int USS_CR_SW_CLK = 1;
  localparam int USS_CR_TOGGLE = 0;
  // -------------------------------------------------------------------------
  // status field positions
  // -------------------------------------------------------------------------
  localparam int USS_SR_START = 7;
  localparam int USS_SR_OVF = 6;
  localparam int USS_SR_STOP = 5;
  localparam int USS_SR_COLL = 4;
  localparam int USS_SR_CNT_HI = 3;
  localparam int USS_SR_CNT_LO = 0;
  // -------------------------------------------------------------------------
  // field encodings
  // -------------------------------------------------------------------------
  localparam logic [1:0] USS_WM_OFF = 2'h0;
  localparam logic [1:0] USS_WM_THREE = 2'h1;
  localparam logic [1:0] USS_WM_TWO = 2'h2;
  localparam logic [1:0] USS_WM_TWO_HOLD = 2'h3;
  localparam logic [1:0] USS_CS_SOFT = 2'h0;
  localparam logic [1:0] USS_CS_TIMER = 2'h1;
  localparam logic [3:0] USS_CNT_MAX = 4'hF;
  localparam logic [3:0] USS_CNT_ONE = 4'h1;
  // -------------------------------------------------------------------------
  // timing: data-line delay before compare with the clock line
  // -------------------------------------------------------------------------
  localparam int USS_CLK_PERIOD_PS = 4000;
  localparam int USS_SDA_DELAY_MIN_NS = 50;
  localparam int USS_SDA_DELAY_MAX_NS = 300;
  localparam int USS_SDA_DELAY_CYC_RAW = (USS_SDA_DELAY_MIN_NS * 1000 + USS_CLK_PERIOD_PS - 1)
                                         / USS_CLK_PERIOD_PS;
  localparam int USS_SDA_DELAY_CYC = (USS_SDA_DELAY_CYC_RAW < 1) ? 1 : USS_SDA_DELAY_CYC_RAW;
endpackage

// >>> sim/uss_core_properties.sv
// port-level assertions for the serial shift core, bound to every instance
`timescale 1ns/1ps
module uss_core_props
  import uss_pkg::*;
#(
  parameter int SYNC_STAGES = 3
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic i_global_ie,
  input wire logic i_data_dir,
  input wire logic o_data_out,
  input wire logic o_data_oe_n,
  input wire logic o_clock_out,
  input wire logic o_clock_oe_n,
  input wire logic o_start_irq,
  input wire logic o_overflow_irq,
  input wire logic o_start_wake
);
  // -------------------------------------------------------------------------
  // wire-mode shadow and properties
  // -------------------------------------------------------------------------
  logic [1:0] wm_q;
  logic [1:0] wm_d;
  // shadow follows control writes so mode-dependent pin rules can be judged
  always_comb begin
    wm_d = !i_resetn ? USS_WM_OFF : (i_wr && i_addr == USS_ADDR_CONTROL) ? i_wdata[5:4] : wm_q;
  end
  always_ff @(posedge i_clk) begin
    wm_q <= wm_d;
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);
  a_start_needs_gie: assert property (o_start_irq |-> i_global_ie)
    else $error("start request without global enable");
  a_ovf_needs_gie: assert property (o_overflow_irq |-> i_global_ie)
    else $error("overflow request without global enable");
  a_wake_follows_start: assert property (o_start_wake == o_start_irq)
    else $error("wake output differs from start request");
  a_strobes_read_zero: assert property
    ($past(i_rd) && $past(i_addr) == USS_ADDR_CONTROL |-> o_rdata[1:0] == 2'h0)
    else $error("strobe bits read back non-zero");
  a_dir_gates_data: assert property (!o_data_oe_n |-> i_data_dir)
    else $error("data driven with direction bit clear");
  a_off_mode_quiet: assert property (wm_q == USS_WM_OFF |-> o_data_oe_n && o_clock_oe_n)
    else $error("pin driven with outputs disabled");
  a_open_drain_low: assert property
    (wm_q[1] |-> !o_clock_out && (o_data_oe_n || !o_data_out))
    else $error("two-wire pin driven high");
  a_start_flag_holds: assert property
    (o_start_irq && !i_wr |=> o_start_irq || !i_global_ie)
    else $error("start request dropped without a write");
  a_ovf_flag_holds: assert property
    (o_overflow_irq && !i_wr |=> o_overflow_irq || !i_global_ie)
    else $error("overflow request dropped without a write");
  c_start: cover property ($rose(o_start_irq));
  c_ovf: cover property ($rose(o_overflow_irq));
  c_hold: cover property (!o_clock_oe_n);
  c_drive: cover property (!o_data_oe_n);
endmodule

bind uss_core uss_core_props #(.SYNC_STAGES(SYNC_STAGES)) u_props (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_global_ie(i_global_ie),
  .i_data_dir(i_data_dir), .o_data_out(o_data_out), .o_data_oe_n(o_data_oe_n),
  .o_clock_out(o_clock_out), .o_clock_oe_n(o_clock_oe_n), .o_start_irq(o_start_irq),
  .o_overflow_irq(o_overflow_irq), .o_start_wake(o_start_wake)
);

// >>> sim/uss_partner.sv
// behavioural far-side master for the serial data and clock lines
`timescale 1ns/1ps
module uss_partner (
  input wire logic i_data_oe_n,
  input wire logic i_data_out,
  input wire logic i_clock_oe_n,
  output logic o_sda,
  output logic o_scl
);
  logic sda_drv = 1'b1;
  logic scl_drv = 1'b1;
  // open-drain lines with pull-ups: whoever pulls low wins
  assign o_sda = sda_drv & (i_data_oe_n | i_data_out);
  assign o_scl = scl_drv & i_clock_oe_n;
  // a slave may stretch the clock; give up after 2 us rather than hang
  task automatic wait_scl();
    for (int k = 0; k < 500 && !o_scl; k++) #4;
  endtask
  // n bits msb first at a 32 ns period; clock idles high between frames
  task automatic bits(input logic [7:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      scl_drv = 1'b0;
      sda_drv = v[i];
      #16;
      scl_drv = 1'b1;
      wait_scl();
      #16;
    end
    sda_drv = 1'b1;
  endtask
  // start: data falls with the clock high, then the clock falls
  task automatic send_start();
    sda_drv = 1'b0;
    #120;
    scl_drv = 1'b0;
    #120;
    scl_drv = 1'b1;
  endtask
  // stop: data rises with the clock high
  task automatic send_stop();
    scl_drv = 1'b0;
    #40;
    sda_drv = 1'b0;
    #40;
    scl_drv = 1'b1;
    wait_scl();
    #120;
    sda_drv = 1'b1;
    #120;
  endtask
endmodule

// >>> sim/test_uss_core.sv
// self-checking bench for the serial shift core
`timescale 1ns/1ps
module test_uss_core;
  import uss_pkg::*;
  typedef struct packed {logic [7:0] a; logic [7:0] w; logic [7:0] e;} uss_row_t;
  logic i_clk, i_resetn, i_wr, i_rd, i_global_ie, i_timer_match;
  logic i_data_dir, i_clock_dir, i_data_port, i_clock_port;
  logic [7:0] i_addr, i_wdata, o_rdata, v;
  logic o_data_out, o_data_oe_n, o_clock_out, o_clock_oe_n, o_start_irq, o_overflow_irq;
  logic o_start_wake;
  wire sda, scl;
  int err_count = 0;
  int check_count = 0;
  uss_row_t rows [8] = '{
    '{8'hB8, 8'hF0, 8'hF0}, '{8'hB8, 8'h07, 8'h04}, '{8'hBA, 8'hA5, 8'hA5},
    '{8'hBB, 8'h3C, 8'h00}, '{8'hB9, 8'h0F, 8'h0F}, '{8'hC0, 8'h55, 8'h00},
    '{8'hB9, 8'h00, 8'h00}, '{8'hB8, 8'h00, 8'h00}};
  uss_core #(.SYNC_STAGES(3)) dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_global_ie(i_global_ie),
    .i_timer_match(i_timer_match), .i_data_dir(i_data_dir), .i_clock_dir(i_clock_dir),
    .i_data_port(i_data_port), .i_clock_port(i_clock_port), .i_serial_in_pin(sda),
    .i_shift_clock_pin(scl), .o_data_out(o_data_out), .o_data_oe_n(o_data_oe_n),
    .o_clock_out(o_clock_out), .o_clock_oe_n(o_clock_oe_n), .o_start_irq(o_start_irq),
    .o_overflow_irq(o_overflow_irq), .o_start_wake(o_start_wake));
  uss_partner p (.i_data_oe_n(o_data_oe_n), .i_data_out(o_data_out),
    .i_clock_oe_n(o_clock_oe_n), .o_sda(sda), .o_scl(scl));
  // -------------------------------------------------------------------------
  // bus tasks and checking
  // -------------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic m = 1'b0);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    i_timer_match <= m;
    @(posedge i_clk);
    i_wr <= 1'b0;
    i_timer_match <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask
  task automatic chk(input string s, input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", s, exp, got);
    end
  endtask
  // clock level, wake, start request, overflow request, clock enable, data enable
  function automatic logic [7:0] pins();
    return {2'h0, o_clock_out, o_start_wake, o_start_irq, o_overflow_irq, o_clock_oe_n,
            o_data_oe_n};
  endfunction
  task automatic close_out();
    if (err_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  // run is well under a thousand cycles; 25000 means something hung
  initial begin
    #100000;
    err_count++;
    close_out();
  end
  initial begin
    {i_wr, i_rd, i_timer_match, i_data_dir, i_addr, i_wdata} = '0;
    {i_resetn, i_global_ie, i_clock_dir, i_data_port, i_clock_port} = 5'h0F;
    repeat (10) @(posedge i_clk);
    i_resetn <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, v);
      chk("register", v, rows[i].e);
    end
    // software strobe: shift, count wrap, buffer copy, flag clear
    wr(8'hB9, 8'h0F); wr(8'hBA, 8'h81); wr(8'hB8, 8'h42);
    rd(8'hBA, v); chk("sw shift", v, 8'h03);
    rd(8'hB9, v); chk("ovf status", v & 8'hEF, 8'h40);
    chk("ovf pins", pins(), 8'h07);
    rd(8'hBB, v); chk("buffer", v, 8'h03);
    wr(8'hB8, 8'h40); rd(8'hBA, v); chk("no clock", v, 8'h03);
    wr(8'hB9, 8'h40); chk("ovf clear", pins(), 8'h03);
    // timer source: a coincident write wins, a lone match shifts
    wr(8'hB8, 8'h04); wr(8'hBA, 8'h5A, 1'b1);
    rd(8'hBA, v); chk("write wins", v, 8'h5A);
    wr(8'hC0, 8'h00, 1'b1); rd(8'hBA, v); chk("timer shift", v, 8'hB5);
    // external clock with outputs off: both edges count, edges set start flag
    wr(8'hBA, 8'h00); wr(8'hB9, 8'hE0); wr(8'hB8, 8'h88);
    p.bits(8'h02, 2);
    repeat (20) @(posedge i_clk);
    rd(8'hBA, v); chk("ext shift", v, 8'h02);
    rd(8'hB9, v); chk("ext status", v & 8'hCF, 8'h84);
    chk("ext pins", pins(), 8'h1B);
    wr(8'hB8, 8'h0A); wr(8'hB8, 8'h0B); wr(8'hB8, 8'h0B);
    rd(8'hB9, v); chk("toggle count", v & 8'h0F, 8'h06);
    // falling-edge shift takes the bit held through the high phase before it
    wr(8'hBA, 8'h00); wr(8'hB8, 8'h0C); p.bits(8'h01, 2);
    repeat (20) @(posedge i_clk);
    rd(8'hBA, v); chk("fall shift", v, 8'h02);
    // start condition ignored with outputs off
    wr(8'hB8, 8'h80); wr(8'hB9, 8'hE0); p.send_start(); p.send_stop();
    rd(8'hB9, v); chk("off start", v & 8'h80, 8'h00);
    // two-wire start hold, release, then stop flag set and cleared
    wr(8'hB8, 8'hA0); wr(8'hB9, 8'hE0); p.send_start();
    repeat (10) @(posedge i_clk);
    #1;
    chk("start hold", pins(), 8'h19);
    wr(8'hB9, 8'h80); chk("start release", pins(), 8'h03);
    p.send_stop(); rd(8'hB9, v); chk("stop", v & 8'hE0, 8'h20);
    wr(8'hB9, 8'h20); rd(8'hB9, v); chk("stop clear", v & 8'hE0, 8'h00);
    // mode 11 overflow hold and release, then collision both ways
    wr(8'hB9, 8'hEF); wr(8'hB8, 8'h72);
    repeat (4) @(posedge i_clk);
    #1;
    chk("ovf hold", pins(), 8'h05);
    wr(8'hB9, 8'h40); chk("ovf release", pins(), 8'h03);
    for (int i = 0; i < 2; i++) begin
      wr(8'hBA, {i[0], 7'h0}); rd(8'hB9, v);
      chk("collision", v & 8'h10, {3'h0, ~i[0], 4'h0});
    end
    // three-wire data pin gated by direction, follows bit 7
    wr(8'hB8, 8'h10); chk("dir off", {7'h0, o_data_oe_n}, 8'h01);
    @(posedge i_clk);
    i_data_dir <= 1'b1;
    wr(8'hBA, 8'h80); chk("data pin", {6'h0, o_data_oe_n, o_data_out}, 8'h01);
    // second reset mid-run: every register back to zero
    @(posedge i_clk);
    i_resetn <= 1'b0;
    repeat (10) @(posedge i_clk);
    i_resetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(8'hB8 + 8'(i), v);
      chk("reset", v & (i == 1 ? 8'hEF : 8'hFF), USS_RESET_VALUE);
    end
    close_out();
  end
endmodule
